// ### design/flash_writer_status_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
module flash_writer_status_ctrl
  import flash_writer_status_pkg::*;
(
  input wire logic i_mclk,
  input wire logic i_reset,
  input wire logic i_ce_n,
  input wire logic i_we_n,
  input wire logic i_oe_n,
  input wire logic [7:0] i_data,
  input wire logic [7:0] i_mem_data,
  input wire logic i_op_done,
  input wire logic i_prog_err,
  input wire logic i_erase_err,
  input wire logic i_overcount,
  input wire logic i_bad_addr,
  output logic [7:0] o_data,
  output logic o_data_oe,
  output logic o_start_program,
  output logic o_start_erase,
  output logic o_mem_read_mode,
  output logic o_cmd_wait
);
  logic we_rise;
  logic oe_rise;
  logic oe_level;
  logic ce_level;
  logic [7:0] data_m_q;
  logic [7:0] data_s_q;
  mode_t mode_q;
  mode_t mode_d;
  logic is_erase_q;
  logic is_erase_d;
  logic [7:0] status_q;
  logic [7:0] status_d;
  logic [7:0] out_q;
  logic [7:0] out_d;
  logic prog_q;
  logic prog_d;
  logic erase_q;
  logic erase_d;
  logic write_cmd;
  logic read_end;
  logic ce_last_q;

  strobe_sync u_we (
    .i_mclk(i_mclk),
    .i_reset(i_reset),
    .i_pin(i_we_n),
    .o_level(),
    .o_rise(we_rise)
  );

  strobe_sync u_oe (
    .i_mclk(i_mclk),
    .i_reset(i_reset),
    .i_pin(i_oe_n),
    .o_level(oe_level),
    .o_rise(oe_rise)
  );

  strobe_sync u_ce (
    .i_mclk(i_mclk),
    .i_reset(i_reset),
    .i_pin(i_ce_n),
    .o_level(ce_level),
    .o_rise()
  );

  always_ff @(posedge i_mclk or posedge i_reset)
  begin
    if (i_reset)
    begin
      data_m_q <= 8'h00;
      data_s_q <= 8'h00;
      ce_last_q <= 1'b1;
    end
    else
    begin
      data_m_q <= i_data;
      data_s_q <= data_m_q;
      ce_last_q <= ce_level;
    end
  end

  // A command is taken at the rising edge of the write strobe while selected.
  assign write_cmd = we_rise & ~ce_level;
  // A read ends at the output enable rise; the select of the cycle before counts.
  // This lets chip enable rise together with output enable.
  assign read_end = oe_rise & ~ce_last_q;

  always_comb
  begin
    mode_d = mode_q;
    is_erase_d = is_erase_q;
    status_d = status_q;
    prog_d = 1'b0;
    erase_d = 1'b0;
    unique case (mode_q)
      ST_MEM_READ, ST_CMD_WAIT, ST_AUTO_DONE:
      begin
        // Memory read mode decodes commands like the wait state.
        if (write_cmd)
        begin
          if (data_s_q == CMD_MEM_READ)
          begin
            mode_d = ST_MEM_READ;
          end
          else if (data_s_q == CMD_AUTO_PROGRAM)
          begin
            mode_d = ST_AUTO_RUN;
            is_erase_d = 1'b0;
            prog_d = 1'b1;
            status_d = STATUS_RESET;
          end
          else if (data_s_q == CMD_AUTO_ERASE)
          begin
            mode_d = ST_AUTO_RUN;
            is_erase_d = 1'b1;
            erase_d = 1'b1;
            status_d = STATUS_RESET;
          end
          else if (data_s_q == CMD_STATUS_READ)
          begin
            mode_d = ST_STATUS;
          end
          else
          begin
            status_d[STAT_CMD_ERR] = 1'b1;
            status_d[STAT_ABNORMAL] = 1'b1;
            mode_d = ST_CMD_WAIT;
          end
        end
        else if (mode_q == ST_AUTO_DONE && read_end)
        begin
          mode_d = ST_CMD_WAIT;
        end
      end
      ST_AUTO_RUN:
      begin
        if (i_op_done)
        begin
          mode_d = ST_AUTO_DONE;
          status_d[STAT_PROG_ERR] = ~is_erase_q & i_prog_err;
          status_d[STAT_ERASE_ERR] = is_erase_q & i_erase_err;
          status_d[STAT_OVERCOUNT] = i_overcount;
          status_d[STAT_BAD_ADDR] = i_bad_addr;
          status_d[STAT_ABNORMAL] = (is_erase_q ? i_erase_err : i_prog_err)
            | i_overcount | i_bad_addr;
        end
      end
      ST_STATUS:
      begin
        if (read_end)
        begin
          mode_d = ST_CMD_WAIT;
        end
      end
      default:
      begin
        mode_d = ST_CMD_WAIT;
      end
    endcase
  end

  always_comb
  begin
    out_d = 8'h00;
    unique case (mode_q)
      ST_MEM_READ:
      begin
        out_d = i_mem_data;
      end
      ST_STATUS:
      begin
        out_d = status_q & 8'hF3;
      end
      ST_AUTO_RUN:
      begin
        out_d = 8'h00;
      end
      ST_AUTO_DONE:
      begin
        out_d = {1'b1, ~status_q[STAT_ABNORMAL], 6'h00};
      end
      default:
      begin
        out_d = 8'h00;
      end
    endcase
  end

  always_ff @(posedge i_mclk or posedge i_reset)
  begin
    if (i_reset)
    begin
      mode_q <= ST_MEM_READ;
      is_erase_q <= 1'b0;
      status_q <= STATUS_RESET;
      out_q <= 8'h00;
      prog_q <= 1'b0;
      erase_q <= 1'b0;
    end
    else
    begin
      mode_q <= mode_d;
      is_erase_q <= is_erase_d;
      status_q <= status_d;
      out_q <= out_d;
      prog_q <= prog_d;
      erase_q <= erase_d;
    end
  end

  assign o_data = out_q;
  assign o_data_oe = ~oe_level & ~ce_level;
  assign o_start_program = prog_q;
  assign o_start_erase = erase_q;
  assign o_mem_read_mode = (mode_q == ST_MEM_READ);
  assign o_cmd_wait = (mode_q == ST_CMD_WAIT);
endmodule
`default_nettype wire

// ### design/flash_writer_status_pkg.sv
// Operation
// - After auto-program, auto-erase or status read ends, enter command wait state.
// - In memory read mode, any number of consecutive reads need no new command.
// - Memory read mode accepts command writes exactly like the command wait state.
// - After power-on the block starts in memory read mode.
// - Status byte: bit7 abnormal end, bits6-4 command/program/erase errors, bits3-2 zero.
// - Status bit1 is set when write or erase attempts were over counted.
// - Status bit0 is set when an invalid effective address error occurred.
// - During auto operations, completion line low while busy, high when done; rest zero.
// - With completion high, result line high for normal end, low for abnormal end.
package flash_writer_status_pkg;
  localparam logic [7:0] CMD_MEM_READ = 8'hFF;
  localparam logic [7:0] CMD_AUTO_PROGRAM = 8'h40;
  localparam logic [7:0] CMD_AUTO_ERASE = 8'h20;
  localparam logic [7:0] CMD_STATUS_READ = 8'h71;
  localparam int STAT_ABNORMAL = 7;
  localparam int STAT_CMD_ERR = 6;
  localparam int STAT_PROG_ERR = 5;
  localparam int STAT_ERASE_ERR = 4;
  localparam int STAT_OVERCOUNT = 1;
  localparam int STAT_BAD_ADDR = 0;
  localparam logic [7:0] STATUS_RESET = 8'h00;
  typedef enum logic [2:0] {
    ST_MEM_READ = 3'b000,
    ST_CMD_WAIT = 3'b001,
    ST_AUTO_RUN = 3'b011,
    ST_AUTO_DONE = 3'b010,
    ST_STATUS = 3'b110
  } mode_t;
endpackage

// ### design/strobe_sync.sv
`timescale 1ns/1ps
`default_nettype none
module strobe_sync
  import flash_writer_status_pkg::*;
(
  input wire logic i_mclk,
  input wire logic i_reset,
  input wire logic i_pin,
  output logic o_level,
  output logic o_rise
);
  logic meta_q;
  logic meta_d;
  logic sync_q;
  logic sync_d;
  logic last_q;
  logic last_d;

  always_comb
  begin
    meta_d = i_pin;
    sync_d = meta_q;
    last_d = sync_q;
  end

  always_ff @(posedge i_mclk or posedge i_reset)
  begin
    if (i_reset)
    begin
      meta_q <= 1'b1;
      sync_q <= 1'b1;
      last_q <= 1'b1;
    end
    else
    begin
      meta_q <= meta_d;
      sync_q <= sync_d;
      last_q <= last_d;
    end
  end

  assign o_level = sync_q;
  assign o_rise = sync_q & ~last_q;
endmodule
`default_nettype wire

// ### verif/flash_core_model.sv
`timescale 1ns/1ps
`default_nettype none
module flash_core_model (
  input wire logic i_mclk,
  input wire logic i_reset,
  input wire logic i_start,
  input wire logic [7:0] i_delay,
  output logic o_done
);
  logic [7:0] cnt_q;
  always_ff @(posedge i_mclk or posedge i_reset)
  begin
    if (i_reset)
      cnt_q <= 8'h00;
    else
      cnt_q <= i_start ? i_delay : cnt_q - {7'h00, cnt_q != 8'h00};
  end
  assign o_done = cnt_q == 8'h01;
endmodule
`default_nettype wire

// ### verif/flash_writer_status_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module flash_status_chk (
  input wire logic i_mclk,
  input wire logic i_reset,
  input wire logic i_ce_n,
  input wire logic i_we_n,
  input wire logic i_op_done,
  input wire logic i_prog_err,
  input wire logic i_erase_err,
  input wire logic i_overcount,
  input wire logic i_bad_addr,
  input wire logic [7:0] o_data,
  input wire logic o_data_oe,
  input wire logic o_start_program,
  input wire logic o_start_erase,
  input wire logic o_mem_read_mode,
  input wire logic o_cmd_wait
);
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_reset);
  logic ok;
  logic st;
  logic erase_op_q;
  // Remembers whether the running auto operation is an erase.
  always_ff @(posedge i_mclk or posedge i_reset)
  begin
    if (i_reset)
      erase_op_q <= 1'b0;
    else if (o_start_erase)
      erase_op_q <= 1'b1;
    else if (o_start_program)
      erase_op_q <= 1'b0;
  end
  assign ok = !((erase_op_q ? i_erase_err : i_prog_err) || i_overcount || i_bad_addr);
  assign st = o_start_program || o_start_erase;
  chk_power_read: assert property ($fell(i_reset) |-> o_mem_read_mode)
    else $error("no read mode");
  chk_one_mode: assert property (!(o_mem_read_mode && o_cmd_wait))
    else $error("two modes");
  chk_start_pulse: assert property (st |=> !st)
    else $error("long start");
  chk_busy_poll: assert property (st |=> (o_data == 8'h00) [*2])
    else $error("bad busy");
  chk_done_poll: assert property (i_op_done && !o_data[7] && !o_mem_read_mode && !o_cmd_wait
    |-> ##2 o_data == {1'b1, $past(ok, 2), 6'h00})
    else $error("bad poll");
  chk_status_zero: assert property (!o_mem_read_mode && !$past(o_mem_read_mode)
    |-> o_data[3:2] == 2'b00)
    else $error("bits set");
  chk_oe_idle: assert property (i_ce_n && $past(i_ce_n) && $past(i_ce_n, 2) |-> !o_data_oe)
    else $error("bad drive");
  chk_read_stays: assert property ($fell(o_mem_read_mode)
    |-> !($past(i_we_n, 5) && $past(i_we_n, 6) && $past(i_we_n, 7)))
    else $error("left read");
  cover property (o_start_program);
  cover property (o_start_erase);
  cover property ($rose(o_cmd_wait));
endmodule
bind flash_writer_status_ctrl flash_status_chk i_flash_status_chk (
  .i_mclk(i_mclk), .i_reset(i_reset), .i_ce_n(i_ce_n), .i_we_n(i_we_n),
  .i_op_done(i_op_done), .i_prog_err(i_prog_err), .i_erase_err(i_erase_err),
  .i_overcount(i_overcount), .i_bad_addr(i_bad_addr),
  .o_data(o_data), .o_data_oe(o_data_oe), .o_start_program(o_start_program),
  .o_start_erase(o_start_erase), .o_mem_read_mode(o_mem_read_mode), .o_cmd_wait(o_cmd_wait)
);
`default_nettype wire

// ### verif/test_flash_writer_status_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
module test_flash_writer_status_ctrl
  import flash_writer_status_pkg::*;
;
  logic mclk = 1'b0;
  logic reset = 1'b1;
  logic ce_n = 1'b1;
  logic we_n = 1'b1;
  logic oe_n = 1'b1;
  logic [7:0] data = 8'h00;
  logic [7:0] mem_data = 8'hAC;
  logic [3:0] errs = 4'h0;
  logic [7:0] dly = 8'h04;
  logic [7:0] rdata;
  logic oe, st_p, st_e, mode_r, mode_w, done;
  int checks = 0;
  int miscompares = 0;
  int prog_starts = 0;
  int erase_starts = 0;
  always @(posedge mclk)
  begin
    if (st_p === 1'b1)
      prog_starts++;
    if (st_e === 1'b1)
      erase_starts++;
  end
  always #5 mclk = ~mclk;
  flash_writer_status_ctrl i_flash_writer_status_ctrl (
    .i_mclk(mclk), .i_reset(reset), .i_ce_n(ce_n), .i_we_n(we_n), .i_oe_n(oe_n),
    .i_data(data), .i_mem_data(mem_data), .i_op_done(done), .i_prog_err(errs[3]),
    .i_erase_err(errs[2]), .i_overcount(errs[1]), .i_bad_addr(errs[0]), .o_data(rdata),
    .o_data_oe(oe), .o_start_program(st_p), .o_start_erase(st_e),
    .o_mem_read_mode(mode_r), .o_cmd_wait(mode_w)
  );
  flash_core_model i_flash_core_model (
    .i_mclk(mclk), .i_reset(reset), .i_start(st_p | st_e), .i_delay(dly), .o_done(done)
  );
  task end_of_test();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task cyc(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  task chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    checks++;
    if (g !== e)
    begin
      $display("wrong value %s expected %h seen %h", nm, e, g);
      miscompares++;
    end
  endtask
  task wr(input logic [7:0] c);
    ce_n = 1'b0;
    data = c;
    we_n = 1'b0;
    cyc(3);
    we_n = 1'b1;
    cyc(6);
    ce_n = 1'b1;
    data = ~c;
    cyc(1);
  endtask
  task rd(input string nm, input logic [7:0] e);
    ce_n = 1'b0;
    oe_n = 1'b0;
    cyc(4);
    chk("drive", 8'h01, {7'h00, oe});
    chk(nm, e, rdata);
    oe_n = 1'b1;
    ce_n = 1'b1;
    cyc(6);
  endtask
  task auto(input logic [7:0] c, input logic [3:0] f, input logic [7:0] d,
    input logic [7:0] pol, input logic [7:0] sta);
    int n;
    errs = f;
    dly = d;
    wr(c);
    for (n = 0; n < 200 && rdata[7] !== 1'b1; n++)
      cyc(1);
    if (n == 200)
    begin
      miscompares++;
      end_of_test();
    end
    rd("poll", pol);
    chk("cmd_wait", 8'h01, {7'h00, mode_w});
    wr(CMD_STATUS_READ);
    rd("status", sta);
    chk("cmd_wait", 8'h01, {7'h00, mode_w});
    $display("auto test done");
  endtask
  initial
  begin
    cyc(2);
    reset = 1'b0;
    cyc(3);
    chk("read_mode", 8'h01, {7'h00, mode_r});
    rd("mem", 8'hAC);
    mem_data = 8'h5C;
    rd("mem", 8'h5C);
    wr(CMD_STATUS_READ);
    rd("status", 8'h00);
    chk("cmd_wait", 8'h01, {7'h00, mode_w});
    wr(CMD_MEM_READ);
    chk("read_mode", 8'h01, {7'h00, mode_r});
    $display("read test done");
    auto(CMD_AUTO_PROGRAM, 4'h0, 8'h04, 8'hC0, 8'h00);
    wr(CMD_MEM_READ);
    wr(8'h55);
    chk("cmd_wait", 8'h01, {7'h00, mode_w});
    wr(CMD_STATUS_READ);
    rd("status", 8'hC0);
    auto(CMD_AUTO_PROGRAM, 4'h8, 8'h04, 8'h80, 8'hA0);
    auto(CMD_AUTO_ERASE, 4'h7, 8'h28, 8'h80, 8'h93);
    chk("prog_starts", 8'h02, prog_starts[7:0]);
    chk("erase_starts", 8'h01, erase_starts[7:0]);
    end_of_test();
  end
endmodule
`default_nettype wire
